// File: include/ipa_regs.svh
// Behaviour
// - a read of the pending-clear register returns one for each source that is pending now.
// - writing one to a pending-clear bit removes that source's pending state, unless its request line is high in that cycle.
// - writing zero to a pending-clear bit leaves that source's pending state as it was.
// - bit 15 is the direct memory access source and bit 14 the bridge driver source.
// - bits 13 and 12 are external interrupt inputs one and zero.
// - bits 11 and 10 are serial ports two and one, bits 9 and 8 sync channels two and one.
// - bits 7 down to 4 are capture/compare service requests three down to zero.
// - bit 3 is converter one, bit 2 measurement and converter two, bits 1 and 0 timers two and one.
// - the active-flag register is read-only and shows each source's active state per bit.
// - bits 31 to 16 of pending-clear and active-flag registers are reserved and read zero.
// - each priority byte stores only its upper four bits; the lower four read zero.
// - writing one to a pending-set bit makes that source pending, zero does nothing.
// - writing one to an enable-clear bit disables that source; reads show enable state.
`ifndef IPA_REGS_SVH
`define IPA_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define IPA_OFF_ENABLE_SET    12'h100
`define IPA_OFF_ENABLE_CLEAR  12'h180
`define IPA_OFF_PENDING_SET   12'h200
`define IPA_OFF_PENDING_CLEAR 12'h280
`define IPA_OFF_ACTIVE_FLAGS  12'h300
`define IPA_OFF_PRIO_FIRST    12'h400
`define IPA_OFF_PRIO_LAST     12'h40c
`define IPA_OFF_ACK           12'h500
`define IPA_OFF_EOI           12'h504
`define IPA_OFF_IRQ_STATUS    12'h600
`define IPA_OFF_IRQ_MASK      12'h604

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define IPA_NSRC        16
`define IPA_PRIO_KEEP   8'hf0
`define IPA_RESET_WORD  32'h0000_0000
`define IPA_EV_PEND     0
`define IPA_EV_ACK      1
`define IPA_NEV         2

// source bit positions
`define IPA_SRC_DMA_BIT             15
`define IPA_SRC_BRIDGE_DRIVER_BIT   14
`define IPA_SRC_EXT_INPUT1_BIT      13
`define IPA_SRC_EXT_INPUT0_BIT      12
`define IPA_SRC_SERIAL_PORT2_BIT    11
`define IPA_SRC_SERIAL_PORT1_BIT    10
`define IPA_SRC_SYNC_CHANNEL2_BIT   9
`define IPA_SRC_SYNC_CHANNEL1_BIT   8
`define IPA_SRC_CAPCOMP_REQ3_BIT    7
`define IPA_SRC_CAPCOMP_REQ0_BIT    4
`define IPA_SRC_CONVERTER1_BIT      3
`define IPA_SRC_CONVERTER2_BIT      2
`define IPA_SRC_TIMER_BLOCK2_BIT    1
`define IPA_SRC_TIMER_BLOCK1_BIT    0

`endif

// File: include/ipa_pkg.sv
package ipa_pkg;
   typedef enum logic [1:0] {
      IPA_IDLE,
      IPA_ANSWER
   } ipa_bus_state_t;
   typedef logic [15:0] ipa_src_vec_t;
endpackage

// File: design/ipa_src_cell.sv
`timescale 1ns/1ps
`include "ipa_regs.svh"

module ipa_src_cell (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // source request
   input wire logic req,
   // software strokes
   input wire logic set_en,
   input wire logic clr_en,
   input wire logic set_pend,
   input wire logic clr_pend,
   input wire logic ack,
   input wire logic eoi,
   // state
   output logic enabled,
   output logic pending,
   output logic active
);
   logic en_q, en_d, pend_q, pend_d, act_q, act_d;

   always_comb begin
      en_d = en_q;
      if (clr_en) begin
         en_d = 1'b0;
      end else if (set_en) begin
         en_d = 1'b1;
      end
      pend_d = pend_q;
      if (clr_pend || ack) begin
         pend_d = 1'b0;
      end
      if (set_pend || req) begin
         pend_d = 1'b1;
      end
      act_d = act_q;
      if (eoi) begin
         act_d = 1'b0;
      end
      if (ack) begin
         act_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         en_q <= 1'b0;
         pend_q <= 1'b0;
         act_q <= 1'b0;
      end else begin
         en_q <= en_d;
         pend_q <= pend_d;
         act_q <= act_d;
      end
   end

   assign enabled = en_q;
   assign pending = pend_q;
   assign active = act_q;
endmodule

// File: design/ipa_ctrl.sv
`timescale 1ns/1ps
`include "ipa_regs.svh"

module ipa_ctrl #(
   parameter int NSRC = `IPA_NSRC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // avalon-mm slave
   input wire logic [11:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic [1:0] response,
   // peripheral requests
   input wire logic [NSRC-1:0] src_req,
   // core side
   output logic [NSRC-1:0] irq_pending_en,
   output logic irq
);
   // the bit map is fixed, so no other source count can be served
   generate
      if (NSRC != `IPA_NSRC) begin : g_bad_nsrc
         $error("ipa_ctrl: only sixteen sources are mapped");
      end
   endgenerate

   // ----------------------------------------
   // bus handshake
   // ----------------------------------------
   // one wait cycle: the request is taken when waitrequest is low
   ipa_pkg::ipa_bus_state_t st_q, st_d;
   logic take, seen;

   always_comb begin
      st_d = ipa_pkg::IPA_IDLE;
      case (st_q)
         ipa_pkg::IPA_IDLE: begin
            if (read || write) begin
               st_d = ipa_pkg::IPA_ANSWER;
            end
         end
         ipa_pkg::IPA_ANSWER: st_d = ipa_pkg::IPA_IDLE;
         default: st_d = ipa_pkg::IPA_IDLE;
      endcase
   end

   assign waitrequest = (read || write) && (st_q != ipa_pkg::IPA_ANSWER);
   assign take = (st_q == ipa_pkg::IPA_ANSWER) && (read || write);
   assign seen = (st_q == ipa_pkg::IPA_IDLE) && (read || write);

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      mapped = hit(a, `IPA_OFF_ENABLE_SET) || hit(a, `IPA_OFF_ENABLE_CLEAR)
         || hit(a, `IPA_OFF_PENDING_SET) || hit(a, `IPA_OFF_PENDING_CLEAR)
         || hit(a, `IPA_OFF_ACTIVE_FLAGS) || hit(a, `IPA_OFF_ACK)
         || hit(a, `IPA_OFF_EOI) || hit(a, `IPA_OFF_IRQ_STATUS)
         || hit(a, `IPA_OFF_IRQ_MASK)
         || (a >= `IPA_OFF_PRIO_FIRST && a <= `IPA_OFF_PRIO_LAST && a[1:0] == 2'b00);
   endfunction

   logic wr, wr_lo, wr_hi;
   logic [15:0] wlo;
   assign wr = take && write;
   assign wr_lo = wr && byteenable[0];
   assign wr_hi = wr && byteenable[1];
   // lanes gated per byte so a partial write only touches its own lane
   assign wlo = {wr_hi ? writedata[15:8] : 8'h00, wr_lo ? writedata[7:0] : 8'h00};

   // ----------------------------------------
   // per-source state
   // ----------------------------------------
   // bit index equals source
   logic [NSRC-1:0] en_v, pend_v, act_v, ack_v, eoi_v;
   genvar g;
   generate
      for (g = 0; g < NSRC; g++) begin : g_src
         ipa_src_cell u_cell (
            .clk(clk),
            .rst_n(rst_n),
            .req(src_req[g]),
            .set_en(hit(address, `IPA_OFF_ENABLE_SET) && wlo[g]),
            .clr_en(hit(address, `IPA_OFF_ENABLE_CLEAR) && wlo[g]),
            .set_pend(hit(address, `IPA_OFF_PENDING_SET) && wlo[g]),
            .clr_pend(hit(address, `IPA_OFF_PENDING_CLEAR) && wlo[g]),
            .ack(ack_v[g]),
            .eoi(eoi_v[g]),
            .enabled(en_v[g]),
            .pending(pend_v[g]),
            .active(act_v[g])
         );
         assign ack_v[g] = hit(address, `IPA_OFF_ACK) && wlo[g] && pend_v[g];
         assign eoi_v[g] = hit(address, `IPA_OFF_EOI) && wlo[g];
      end
   endgenerate

   assign irq_pending_en = pend_v & en_v;

   // ----------------------------------------
   // priority bytes
   // ----------------------------------------
   logic [31:0] prio_q [4], prio_d [4];
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         prio_d[i] = prio_q[i];
         if (wr && address == `IPA_OFF_PRIO_FIRST + 12'(i * 4)) begin
            for (int b = 0; b < 4; b++) begin
               if (byteenable[b]) begin
                  prio_d[i][b*8 +: 8] = writedata[b*8 +: 8] & `IPA_PRIO_KEEP;
               end
            end
         end
      end
   end

   // ----------------------------------------
   // interrupt status and mask
   // ----------------------------------------
   logic [`IPA_NEV-1:0] sts_q, sts_d, msk_q, msk_d, ev;
   assign ev[`IPA_EV_PEND] = |(src_req & ~pend_v);
   assign ev[`IPA_EV_ACK] = |ack_v;

   always_comb begin
      msk_d = msk_q;
      sts_d = sts_q;
      if (hit(address, `IPA_OFF_IRQ_MASK) && wr_lo) begin
         msk_d = writedata[`IPA_NEV-1:0];
      end
      if (hit(address, `IPA_OFF_IRQ_STATUS) && wr_lo) begin
         sts_d = sts_d & ~writedata[`IPA_NEV-1:0];
      end
      // new events win over a clear in the same cycle
      sts_d = sts_d | ev;
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   logic [31:0] rd_d, rd_q;
   logic [1:0] rsp_d, rsp_q;
   always_comb begin
      rd_d = `IPA_RESET_WORD;
      rsp_d = 2'b00;
      if (seen && !mapped(address)) begin
         rsp_d = 2'b11;
      end
      if (seen && read) begin
         if (hit(address, `IPA_OFF_ENABLE_SET) || hit(address, `IPA_OFF_ENABLE_CLEAR)) begin
            rd_d = {16'h0000, en_v};
         end else if (hit(address, `IPA_OFF_PENDING_SET)
               || hit(address, `IPA_OFF_PENDING_CLEAR)) begin
            rd_d = {16'h0000, pend_v};
         end else if (hit(address, `IPA_OFF_ACTIVE_FLAGS)) begin
            rd_d = {16'h0000, act_v};
         end else if (hit(address, `IPA_OFF_IRQ_STATUS)) begin
            rd_d = {30'h0, sts_q};
         end else if (hit(address, `IPA_OFF_IRQ_MASK)) begin
            rd_d = {30'h0, msk_q};
         end else if (address >= `IPA_OFF_PRIO_FIRST && address <= `IPA_OFF_PRIO_LAST) begin
            rd_d = prio_q[address[3:2]];
         end
      end
   end

   // sampled as the request is seen, so it stands in the answer cycle only;
   // a source that pends during that cycle shows on the next read
   assign readdata = rd_q;
   assign response = rsp_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= ipa_pkg::IPA_IDLE;
         sts_q <= 2'h0;
         msk_q <= 2'h0;
         rd_q <= `IPA_RESET_WORD;
         rsp_q <= 2'h0;
         for (int i = 0; i < 4; i++) begin
            prio_q[i] <= `IPA_RESET_WORD;
         end
      end else begin
         st_q <= st_d;
         sts_q <= sts_d;
         msk_q <= msk_d;
         rd_q <= rd_d;
         rsp_q <= rsp_d;
         for (int i = 0; i < 4; i++) begin
            prio_q[i] <= prio_d[i];
         end
      end
   end

   assign irq = |(sts_q & msk_q);
endmodule

// File: tb/ipa_ctrl_sva.sv
`timescale 1ns/1ps
module ipa_ctrl_sva #(
   parameter int NSRC = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // avalon-mm slave
   input wire logic [11:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // sources
   input wire logic [NSRC-1:0] src_req,
   input wire logic [NSRC-1:0] irq_pending_en
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire ans = (read | write) & !waitrequest;
   wire wr_ok = ans & write & (byteenable == 4'hf);
   // a request line high now or one cycle ago may re-pend, so it is left out
   a_answer_next: assert property ((read | write) && waitrequest |=> !waitrequest)
      else $error("answer late");
   a_pend_read: assert property (ans && read && address == 12'h280
      |-> (readdata[15:0] & $past(irq_pending_en)) == $past(irq_pending_en))
      else $error("pending read");
   a_resv_zero: assert property (ans && read && address[11:8] inside {4'h2, 4'h3}
      && address[6:0] == 7'h0 |-> readdata[31:16] == 16'h0) else $error("reserved bits");
   a_clear_one: assert property (wr_ok && address == 12'h280
      && (writedata[15:0] & (src_req | $past(src_req))) == 16'h0
      |=> (irq_pending_en & $past(writedata[15:0])) == 16'h0) else $error("clear missed");
   a_clear_zero: assert property (ans && write && address == 12'h280
      |=> ($past(irq_pending_en) & ~$past(writedata[15:0]) & ~irq_pending_en) == 16'h0)
      else $error("pending lost");
   a_en_clear: assert property (wr_ok && address == 12'h180
      |=> (irq_pending_en & $past(writedata[15:0])) == 16'h0) else $error("enable kept");
   a_prio_nib: assert property (ans && read && address[11:4] == 8'h40
      |-> (readdata & 32'h0f0f_0f0f) == 32'h0) else $error("low nibble");
   a_active_ro: assert property (ans && write && address == 12'h300 && src_req == 16'h0
      && $past(src_req) == 16'h0 |=> $stable(irq_pending_en)) else $error("active written");
endmodule

bind ipa_ctrl ipa_ctrl_sva #(.NSRC(NSRC)) u_ipa_ctrl_sva (.clk(clk), .rst_n(rst_n),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
   .src_req(src_req), .irq_pending_en(irq_pending_en));

// File: tb/ipa_req_model.sv
`timescale 1ns/1ps
module ipa_req_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // commanded levels
   input wire logic [15:0] want,
   // request lines
   output logic [15:0] src_req
);
   always_ff @(posedge clk) begin
      src_req <= rst_n ? want : 16'h0;
   end
endmodule

// File: tb/ipa_ctrl_tb.sv
`timescale 1ns/1ps
module ipa_ctrl_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] address = 12'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [3:0] byteenable = 4'hf;
   logic [31:0] readdata;
   logic waitrequest;
   logic [1:0] response;
   logic [15:0] want = 16'h0;
   logic [15:0] src_req;
   logic [15:0] irq_pending_en;
   logic irq;
   logic [31:0] q;
   logic [1:0] rsp;
   int error_cnt = 0;
   int check_count = 0;
   always #50 clk = ~clk;
   ipa_req_model u_ipa_req_model (.clk(clk), .rst_n(rst_n), .want(want), .src_req(src_req));
   ipa_ctrl u_ipa_ctrl (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .response(response), .src_req(src_req),
      .irq_pending_en(irq_pending_en), .irq(irq));
   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      read <= !w;
      write <= w;
      @(posedge clk);
      // no cycle count is assumed; a hang is ended by the watchdog
      while (waitrequest !== 1'b0) begin
         @(posedge clk);
      end
      q = readdata;
      rsp = response;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask
   task automatic pulse(input logic [15:0] m);
      want <= m;
      repeat (3) @(posedge clk);
      want <= 16'h0;
      repeat (3) @(posedge clk);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd("active", 12'h300, 32'h0);
      rd("pending", 12'h280, 32'h0);
      acc(1'b1, 12'h100, 32'hffff);
      for (int i = 0; i < 16; i++) begin
         pulse(16'h1 << i);
         rd("src map", 12'h280, 32'h1 << i);
         acc(1'b1, 12'h280, 32'h1 << i);
         rd("cleared", 12'h280, 32'h0);
      end
      $display("test source map done");
      acc(1'b1, 12'h200, 32'hffff_a5a5);
      rd("set", 12'h280, 32'ha5a5);
      acc(1'b1, 12'h280, 32'h00f0);
      acc(1'b1, 12'h280, 32'h0);
      rd("kept", 12'h280, 32'ha505);
      acc(1'b1, 12'h300, 32'hffff_ffff);
      rd("ro", 12'h300, 32'h0);
      acc(1'b1, 12'h180, 32'h00ff);
      rd("enable", 12'h180, 32'hff00);
      chk("pend en", 32'ha500, {16'h0, irq_pending_en});
      acc(1'b1, 12'h280, 32'hffff);
      $display("test set clear done");
      acc(1'b1, 12'h200, 32'h0100);
      acc(1'b1, 12'h500, 32'h0100);
      rd("acked", 12'h300, 32'h0100);
      acc(1'b1, 12'h504, 32'h0100);
      rd("eoi", 12'h300, 32'h0);
      want <= 16'h8000;
      repeat (3) @(posedge clk);
      acc(1'b1, 12'h280, 32'h8000);
      rd("repend", 12'h280, 32'h8000);
      want <= 16'h0;
      repeat (3) @(posedge clk);
      acc(1'b1, 12'h280, 32'hffff);
      rd("gone", 12'h280, 32'h0);
      for (int k = 0; k < 4; k++) begin
         acc(1'b1, 12'h400 + 12'(4 * k), 32'hffff_ffff);
         rd("prio", 12'h400 + 12'(4 * k), 32'hf0f0_f0f0);
      end
      $display("test active prio done");
      acc(1'b1, 12'h600, 32'h3);
      rd("status clr", 12'h600, 32'h0);
      pulse(16'h0200);
      rd("status", 12'h600, 32'h1);
      acc(1'b1, 12'h604, 32'h0);
      chk("irq masked", 32'h0, {31'h0, irq});
      acc(1'b1, 12'h604, 32'h3);
      chk("irq mask", 32'h1, {31'h0, irq});
      acc(1'b1, 12'h600, 32'h1);
      chk("irq idle", 32'h0, {31'h0, irq});
      rd("unmapped", 12'h7fc, 32'h0);
      chk("resp", 32'h3, {30'h0, rsp});
      $display("test irq done");
      tally_and_finish();
   end
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      tally_and_finish();
   end
endmodule
